/* hw/rpmq_intx_level.sv */
`timescale 1ns/1ps
module rpmq_intx_level (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Message events for one line
  input  wire logic hit,
  input  wire logic assertMsg,
  // Live level
  output logic      level_r
);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) level_r <= 1'b0;
    else if (hit) level_r <= assertMsg;
  end
endmodule // rpmq_intx_level

/* hw/rpmq_pkg.sv */
package rpmq_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_MSI_BASE  = 12'h150;
  localparam logic [ADDR_W-1:0] OFF_ERR_HEAD  = 12'h154;
  localparam logic [ADDR_W-1:0] OFF_INT_HDR   = 12'h158;
  localparam logic [ADDR_W-1:0] OFF_INT_PAY   = 12'h15C;
  localparam logic [ADDR_W-1:0] OFF_INTX_STAT = 12'h160;
  localparam logic [ADDR_W-1:0] OFF_QSTAT     = 12'h148;
  localparam int MSI_BASE_LSB  = 12;
  localparam logic [31:0] MSI_BASE_RST = 32'h0000_0000;
  localparam int ERR_RID_LSB   = 0;
  localparam int ERR_TYPE_LSB  = 16;
  localparam int ERR_VALID_BIT = 18;
  localparam int INT_ADDR_LSB  = 16;
  localparam int INT_LINE_LSB  = 27;
  localparam int INT_ASSERT_BIT = 29;
  localparam int INT_MSI_BIT   = 30;
  localparam int INT_VALID_BIT = 31;
  localparam int INTX_STAT_LSB = 16;
  localparam int QS_ERR_NE_BIT = 16;
  localparam int QS_ERR_OV_BIT = 17;
  localparam int QS_INT_NE_BIT = 18;
  localparam int QS_INT_OV_BIT = 19;
  localparam int ERR_W = 18;
  localparam int INT_W = 47;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/rpmq_queue.sv */
`timescale 1ns/1ps
module rpmq_queue #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             pushValid,
  input  wire logic [WIDTH-1:0] pushData,
  // Drain side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] headData,
  output logic                  notEmpty,
  output logic                  full
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    rdPtr_r;
  logic [PW-1:0]    wrPtr_r;
  logic [PW:0]      count_r;
  wire              doPush = pushValid && !full;
  wire              doPop  = pop && notEmpty;
  assign notEmpty = (count_r != '0);
  assign full     = (count_r == (PW+1)'(DEPTH));
  assign headData = mem_r[rdPtr_r];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdPtr_r <= '0;
      wrPtr_r <= '0;
      count_r <= '0;
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else begin
      if (doPush) begin
        mem_r[wrPtr_r] <= pushData;
        wrPtr_r        <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doPop) rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end
endmodule // rpmq_queue

/* hw/rpmq_root_port_msg.sv */
// Overview of operation
// - In root-port mode, memory writes inside MSI window are taken as MSI interrupts.
// - MSI window is exactly 4 KB starting at the programmed base.
// - Base register holds bits 31:12; bits 11:0 read zero.
// - Endpoint configuration reads base and error queue registers as zero.
// - Only one MSI address; no MSI-X or multi-vector addressing.
// - Error queue read shows oldest entry; any write in root-port mode pops it.
// - Error word: requester id 15:0, error type 17:16.
// - Error word bit 18 is valid flag; bits 31:19 read zero.
// - Interrupt header: requester id 15:0, MSI address bits 12:2 in 26:16.
// - Bits 28:27 give INTx line; forced 00b for MSI.
// - Bit 29 is INTx assert flag; zero for MSI.
// - Bit 30 is one for MSI, zero for INTx.
// - Bit 31 is one when an interrupt entry is presented.
// - Interrupt register reads never pop; in root-port mode any write to either pops.
// - Payload word holds MSI data 15:0; zero for INTx.
// - Outside root-port mode, interrupt and INTx status reads return zero.
// - INTA..INTD levels in status bits 16..19 follow assert and deassert.
// - A read-only flag shows the error queue is non-empty.
// - Error message arriving on full queue is dropped; sticky overflow, write-1 clears.
`timescale 1ns/1ps
module rpmq_root_port_msg
  import rpmq_pkg::*;
#(
  parameter int ERR_DEPTH = 4,
  parameter int INT_DEPTH = 4
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  // Mode strap
  input  wire logic                      rootPortMode,
  // Received memory write
  input  wire logic                      memWrValid,
  input  wire logic [63:0]               memWrAddr,
  input  wire logic [15:0]               memWrReqId,
  input  wire logic [15:0]               memWrData,
  output logic                           memWrPass_r,
  // Received error message
  input  wire logic                      errMsgValid,
  input  wire logic [15:0]               errMsgReqId,
  input  wire logic [1:0]                errMsgType,
  // Received INTx message
  input  wire logic                      intxMsgValid,
  input  wire logic [15:0]               intxMsgReqId,
  input  wire logic [1:0]                intxMsgLine,
  input  wire logic                      intxMsgAssert,
  // AXI4-Lite write address
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [rpmq_pkg::ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic      [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [rpmq_pkg::ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic      [31:0]               s_axi_rdata,
  output logic      [1:0]                s_axi_rresp
);
  import rpmq_pkg::*;

  // Write channel capture
  logic                awHeld_r;
  logic                wHeld_r;
  logic [ADDR_W-1:0]   awAddr_r;
  logic [31:0]         wData_r;
  logic [3:0]          wStrb_r;
  logic                bValid_r;
  logic [1:0]          bResp_r;
  logic                rValid_r;
  logic [31:0]         rData_r;
  logic [1:0]          rResp_r;
  logic [31:MSI_BASE_LSB] msiBase_r;
  logic                errOvf_r;
  logic                intOvf_r;
  logic                memPass_r;
  logic [3:0]          intxLevel;
  logic                awReady_r;
  logic                wReady_r;
  logic                arReady_r;

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign memWrPass_r   = memPass_r;

  // Write commits once both address and data are held; response follows both
  wire         wrFire  = awHeld_r && wHeld_r && !bValid_r;
  wire [ADDR_W-1:0] wrWord = {awAddr_r[ADDR_W-1:2], 2'b00};
  wire         wrBase  = wrFire && (wrWord == OFF_MSI_BASE);
  wire         wrErr   = wrFire && (wrWord == OFF_ERR_HEAD);
  wire         wrInt   = wrFire && ((wrWord == OFF_INT_HDR) || (wrWord == OFF_INT_PAY));
  wire         wrQs    = wrFire && (wrWord == OFF_QSTAT);
  wire         wrHit   = (wrWord == OFF_MSI_BASE) || (wrWord == OFF_ERR_HEAD) || (wrWord == OFF_INT_HDR) ||
                         (wrWord == OFF_INT_PAY) || (wrWord == OFF_QSTAT) || (wrWord == OFF_INTX_STAT);

  // Readies are flops loaded with the state after this edge, so no output path is combinational
  wire         awHeld_nxt = !wrFire && (awHeld_r || (s_axi_awvalid && awReady_r));
  wire         wHeld_nxt  = !wrFire && (wHeld_r || (s_axi_wvalid && wReady_r));
  wire         bValid_nxt = wrFire || (bValid_r && !s_axi_bready);
  wire         rValid_nxt = (s_axi_arvalid && arReady_r) || (rValid_r && !s_axi_rready);

  // Only a single window is compared; there is no vector table
  wire         inWindow = (memWrAddr[31:MSI_BASE_LSB] == msiBase_r) && (memWrAddr[63:32] == 32'h0000_0000);
  wire         msiHit   = rootPortMode && memWrValid && inWindow;

  // Error queue
  logic [ERR_W-1:0] errHead;
  logic             errNotEmpty;
  logic             errFull;
  wire              errPop  = wrErr && rootPortMode;
  rpmq_queue #(.WIDTH(ERR_W), .DEPTH(ERR_DEPTH)) errQueue (
    .clock     (clock),
    .rst_b     (rst_b),
    .pushValid (errMsgValid && rootPortMode),
    .pushData  ({errMsgType, errMsgReqId}),
    .pop       (errPop),
    .headData  (errHead),
    .notEmpty  (errNotEmpty),
    .full      (errFull)
  );

  // Interrupt queue entry: {payload, msi, assert, line, addr, reqid}
  wire              intxHit = rootPortMode && intxMsgValid;
  logic [INT_W-1:0] intPush;
  always_comb begin
    if (msiHit) begin
      intPush = {memWrData, 1'b1, 1'b0, 2'b00, memWrAddr[12:2], memWrReqId};
    end else begin
      intPush = {16'h0000, 1'b0, intxMsgAssert, intxMsgLine, 11'h000, intxMsgReqId};
    end
  end
  // MSI takes precedence if both arrive together; the INTx one is then counted as dropped
  logic [INT_W-1:0] intHead;
  logic             intNotEmpty;
  logic             intFull;
  wire              intPop = wrInt && rootPortMode;
  rpmq_queue #(.WIDTH(INT_W), .DEPTH(INT_DEPTH)) intQueue (
    .clock     (clock),
    .rst_b     (rst_b),
    .pushValid (msiHit || intxHit),
    .pushData  (intPush),
    .pop       (intPop),
    .headData  (intHead),
    .notEmpty  (intNotEmpty),
    .full      (intFull)
  );

  // Live INTx levels
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLine
      rpmq_intx_level lineLevel (
        .clock     (clock),
        .rst_b     (rst_b),
        .hit       (intxHit && (intxMsgLine == 2'(g))),
        .assertMsg (intxMsgAssert),
        .level_r   (intxLevel[g])
      );
    end
  endgenerate

  // Read words
  wire [31:0] errWord = errNotEmpty ?
                        {13'h0000, 1'b1, errHead[ERR_W-1:ERR_TYPE_LSB], errHead[15:ERR_RID_LSB]} :
                        32'h0000_0000;
  wire [31:0] intWord1 = intNotEmpty ? {1'b1, intHead[INT_MSI_BIT:0]} : 32'h0000_0000;
  wire [31:0] intWord2 = (intNotEmpty && intHead[INT_MSI_BIT]) ? {16'h0000, intHead[INT_W-1:INT_MSI_BIT+1]} :
                         32'h0000_0000;
  wire [31:0] qsWord   = {12'h000, intOvf_r, intNotEmpty, errOvf_r, errNotEmpty, 16'h0000};
  wire [31:0] baseWord = {msiBase_r, 12'h000};
  wire [31:0] intxWord = {12'h000, intxLevel, 16'h0000};
  wire [ADDR_W-1:0] rdWord = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  logic [31:0] rdMux;
  logic        rdHit;
  always_comb begin
    rdHit = 1'b1;
    case (rdWord)
      OFF_MSI_BASE:  rdMux = baseWord;
      OFF_ERR_HEAD:  rdMux = errWord;
      OFF_INT_HDR:   rdMux = intWord1;
      OFF_INT_PAY:   rdMux = intWord2;
      OFF_INTX_STAT: rdMux = intxWord;
      OFF_QSTAT:     rdMux = qsWord;
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end
  wire [31:0] rdValue = rootPortMode ? rdMux : 32'h0000_0000;

  // Overflow flags: a new drop wins over a clear in the same cycle
  wire errDrop = errMsgValid && rootPortMode && errFull;
  wire intDrop = rootPortMode && ((msiHit || intxHit) && intFull || (msiHit && intxHit));
  wire clrErr  = wrQs && wStrb_r[2] && wData_r[QS_ERR_OV_BIT];
  wire clrInt  = wrQs && wStrb_r[2] && wData_r[QS_INT_OV_BIT];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awAddr_r  <= '0;
      wData_r   <= 32'h0000_0000;
      wStrb_r   <= 4'h0;
      bValid_r  <= 1'b0;
      bResp_r   <= RESP_OKAY;
      msiBase_r <= MSI_BASE_RST[31:MSI_BASE_LSB];
      errOvf_r  <= 1'b0;
      intOvf_r  <= 1'b0;
      memPass_r <= 1'b0;
      awReady_r <= 1'b1;
      wReady_r  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
      if (wrBase && rootPortMode) begin
        for (int b = 1; b < 4; b++) begin
          if (wStrb_r[b]) begin
            for (int k = 8*b; k < 8*b+8; k++) begin
              if (k >= MSI_BASE_LSB) msiBase_r[k] <= wData_r[k];
            end
          end
        end
      end
      if (errDrop) errOvf_r <= 1'b1;
      else if (clrErr) errOvf_r <= 1'b0;
      if (intDrop) intOvf_r <= 1'b1;
      else if (clrInt) intOvf_r <= 1'b0;
      memPass_r <= memWrValid && !msiHit;
      awReady_r <= !awHeld_nxt && !bValid_nxt;
      wReady_r  <= !wHeld_nxt && !bValid_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rData_r  <= rdValue;
      rResp_r  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) arReady_r <= 1'b1;
    else arReady_r <= !rValid_nxt;
  end

  // Checks
  property p_err_pop;
    @(posedge clock) disable iff (!rst_b)
    errPop && errNotEmpty && !(errMsgValid) |=> $changed(errQueue.count_r) || errQueue.count_r == '0;
  endproperty
  a_err_pop: assert property (p_err_pop) else $error("error pop did not dequeue");
  property p_empty_pop;
    @(posedge clock) disable iff (!rst_b)
    intPop && !intNotEmpty && !(msiHit || intxHit) |=> !intNotEmpty;
  endproperty
  a_empty_pop: assert property (p_empty_pop) else $error("pop of empty queue changed it");
  property p_ep_zero;
    @(posedge clock) disable iff (!rst_b)
    s_axi_arvalid && s_axi_arready && !rootPortMode |=> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_ep_zero: assert property (p_ep_zero) else $error("endpoint read not zero");
  property p_base_low;
    @(posedge clock) disable iff (!rst_b)
    s_axi_rvalid |-> !(rData_r != 32'h0 && $past(rdWord) == OFF_MSI_BASE && rData_r[11:0] != 12'h000);
  endproperty
  a_base_low: assert property (p_base_low) else $error("base low bits nonzero");
  property p_ovf;
    @(posedge clock) disable iff (!rst_b)
    errDrop |=> errOvf_r;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
  property p_msi_hdr;
    @(posedge clock) disable iff (!rst_b)
    intNotEmpty && intHead[INT_MSI_BIT] |-> intWord1[29:27] == 3'b000 && intWord1[31];
  endproperty
  a_msi_hdr: assert property (p_msi_hdr) else $error("msi header fields wrong");
  property p_intx_lvl;
    @(posedge clock) disable iff (!rst_b)
    intxHit |=> intxLevel[$past(intxMsgLine)] == $past(intxMsgAssert);
  endproperty
  a_intx_lvl: assert property (p_intx_lvl) else $error("INTx level wrong");
  property p_msi_pass;
    @(posedge clock) disable iff (!rst_b)
    msiHit |=> !memWrPass_r;
  endproperty
  a_msi_pass: assert property (p_msi_pass) else $error("MSI write passed as memory");
  c_msi: cover property (@(posedge clock) disable iff (!rst_b) msiHit);
  c_err_drop: cover property (@(posedge clock) disable iff (!rst_b) errDrop);
  c_int_pop: cover property (@(posedge clock) disable iff (!rst_b) intPop && intNotEmpty);
  c_int_drop: cover property (@(posedge clock) disable iff (!rst_b) intDrop);
  c_intx_asrt: cover property (@(posedge clock) disable iff (!rst_b) intxHit && intxMsgAssert);
  property p_err_resv;
    @(posedge clock) disable iff (!rst_b)
    errNotEmpty |-> errWord[ERR_VALID_BIT] && errWord[31:ERR_VALID_BIT+1] == '0;
  endproperty
  a_err_resv: assert property (p_err_resv) else $error("error word reserved bits wrong");
  property p_intx_pay;
    @(posedge clock) disable iff (!rst_b)
    intNotEmpty && !intHead[INT_MSI_BIT] |-> intWord2 == 32'h0000_0000;
  endproperty
  a_intx_pay: assert property (p_intx_pay) else $error("INTx payload not zero");
  property p_int_empty;
    @(posedge clock) disable iff (!rst_b)
    !intNotEmpty |-> intWord1 == 32'h0000_0000;
  endproperty
  a_int_empty: assert property (p_int_empty) else $error("empty interrupt header not zero");
endmodule // rpmq_root_port_msg

/* verif/rpmq_endpoint_model.sv */
`timescale 1ns/1ps
module rpmq_endpoint_model (
  // Clock
  input  wire logic        clock,
  // Memory write
  output logic             memWrValid,
  output logic [63:0]      memWrAddr,
  output logic [15:0]      memWrReqId,
  output logic [15:0]      memWrData,
  // Error message
  output logic             errMsgValid,
  output logic [15:0]      errMsgReqId,
  output logic [1:0]       errMsgType,
  // INTx message
  output logic             intxMsgValid,
  output logic [15:0]      intxMsgReqId,
  output logic [1:0]       intxMsgLine,
  output logic             intxMsgAssert
);
  initial begin
    memWrValid = 1'h0;
    errMsgValid = 1'h0;
    intxMsgValid = 1'h0;
  end
  // Fields are inverted after each pulse so a stale payload never looks fresh
  task automatic memWr(input logic [63:0] a, input logic [15:0] id, input logic [15:0] d);
    @(posedge clock);
    memWrValid <= 1'h1;
    memWrAddr <= a;
    memWrReqId <= id;
    memWrData <= d;
    @(posedge clock);
    memWrValid <= 1'h0;
    memWrAddr <= ~a;
    memWrReqId <= ~id;
    memWrData <= ~d;
  endtask
  task automatic errMsg(input logic [15:0] id, input logic [1:0] t);
    @(posedge clock);
    errMsgValid <= 1'h1;
    errMsgReqId <= id;
    errMsgType <= t;
    @(posedge clock);
    errMsgValid <= 1'h0;
    errMsgReqId <= ~id;
    errMsgType <= ~t;
  endtask
  task automatic intxMsg(input logic [15:0] id, input logic [1:0] l, input logic asrt);
    @(posedge clock);
    intxMsgValid <= 1'h1;
    intxMsgReqId <= id;
    intxMsgLine <= l;
    intxMsgAssert <= asrt;
    @(posedge clock);
    intxMsgValid <= 1'h0;
    intxMsgReqId <= ~id;
    intxMsgLine <= ~l;
    intxMsgAssert <= ~asrt;
  endtask
endmodule // rpmq_endpoint_model

/* verif/rpmq_root_port_msg_test.sv */
`timescale 1ns/1ps
module rpmq_root_port_msg_test import rpmq_pkg::*; ;
  logic clock, rst_b, rootPortMode, memWrValid, memWrPass_r, errMsgValid, intxMsgValid, intxMsgAssert;
  logic [63:0] memWrAddr;
  logic [15:0] memWrReqId, memWrData, errMsgReqId, intxMsgReqId;
  logic [1:0]  errMsgType, intxMsgLine, bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  int          err_total, num_checks, i;
  rpmq_root_port_msg #(.ERR_DEPTH(4), .INT_DEPTH(4)) DUT (.clock(clock), .rst_b(rst_b),
    .rootPortMode(rootPortMode), .memWrValid(memWrValid), .memWrAddr(memWrAddr), .memWrReqId(memWrReqId),
    .memWrData(memWrData), .memWrPass_r(memWrPass_r), .errMsgValid(errMsgValid), .errMsgReqId(errMsgReqId),
    .errMsgType(errMsgType), .intxMsgValid(intxMsgValid), .intxMsgReqId(intxMsgReqId),
    .intxMsgLine(intxMsgLine), .intxMsgAssert(intxMsgAssert), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  rpmq_endpoint_model farEnd (.clock(clock), .memWrValid(memWrValid), .memWrAddr(memWrAddr),
    .memWrReqId(memWrReqId), .memWrData(memWrData), .errMsgValid(errMsgValid), .errMsgReqId(errMsgReqId),
    .errMsgType(errMsgType), .intxMsgValid(intxMsgValid), .intxMsgReqId(intxMsgReqId),
    .intxMsgLine(intxMsgLine), .intxMsgAssert(intxMsgAssert));
  always #20 clock = ~clock;
  task automatic close_out();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("word %h expected %h", g, e));
  endtask
  task automatic chk2(input logic [1:0] g, input logic [1:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("resp %h expected %h", g, e));
  endtask
  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) fail($sformatf("pass flag %b expected %b", g, e));
  endtask
  // Ready is sampled at the falling edge; it comes from flops, so it equals the value at the next rise
  task automatic axiWr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'h0;
    @(posedge clock);
    awvalid <= 1'h1; awaddr <= a; wvalid <= 1'h1; wdata <= v; wstrb <= 4'hF; bready <= 1'h1;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clock);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end
    if (!tb) begin
      fail("write timeout");
      close_out();
    end
  endtask
  task automatic axiRd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ta, tr;
    tr = 1'h0;
    @(posedge clock);
    arvalid <= 1'h1; araddr <= a; rready <= 1'h1;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge clock);
      ta = arvalid & arready;
      tr = rvalid & rready;
      v = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end
    if (!tr) begin
      fail("read timeout");
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    axiWr(a, v, rs);
    chk2(rs, RESP_OKAY);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    axiRd(a, d, rs);
    chk2(rs, RESP_OKAY);
    chk32(d, e);
  endtask
  task automatic msi(input logic [63:0] a, input logic e);
    farEnd.memWr(a, 16'h0101, 16'hBEEF);
    #1 chk1(memWrPass_r, e);
  endtask
  function automatic logic [31:0] errWord(input logic [15:0] id, input logic [1:0] t);
    return {13'h0, 1'h1, t, id};
  endfunction
  initial begin
    clock = 1'h0; rst_b = 1'h0; rootPortMode = 1'h1; err_total = 0; num_checks = 0;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0; rready = 1'h0;
    awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0; wstrb = 4'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'h1;
    rdChk(OFF_MSI_BASE, 32'h0);
    rdChk(OFF_ERR_HEAD, 32'h0);
    rdChk(OFF_INT_HDR, 32'h0);
    rdChk(OFF_INT_PAY, 32'h0);
    rdChk(OFF_INTX_STAT, 32'h0);
    wr(OFF_MSI_BASE, 32'hFFFF_FFFF);
    rdChk(OFF_MSI_BASE, 32'hFFFF_F000);
    wr(OFF_MSI_BASE, 32'h1234_5000);
    for (i = 0; i < 5; i++) farEnd.errMsg(16'h00A0 + 16'(i), 2'(i % 3));
    rdChk(OFF_QSTAT, 32'h0003_0000);
    wr(OFF_QSTAT, 32'h0002_0000);
    rdChk(OFF_QSTAT, 32'h0001_0000);
    for (i = 0; i < 4; i++) begin
      rdChk(OFF_ERR_HEAD, errWord(16'h00A0 + 16'(i), 2'(i % 3)));
      rdChk(OFF_ERR_HEAD, errWord(16'h00A0 + 16'(i), 2'(i % 3)));
      wr(OFF_ERR_HEAD, 32'h0000_0000);
    end
    wr(OFF_ERR_HEAD, 32'h5A5A_5A5A);
    rdChk(OFF_ERR_HEAD, 32'h0);
    farEnd.errMsg(16'h1234, 2'h2);
    rdChk(OFF_ERR_HEAD, errWord(16'h1234, 2'h2));
    msi(64'h0000_0000_1234_5FFC, 1'h0);
    msi(64'h0000_0000_1234_6000, 1'h1);
    msi(64'h0000_0000_1234_4FFC, 1'h1);
    msi(64'h0000_0001_1234_5008, 1'h1);
    rdChk(OFF_INT_HDR, 32'hC7FF_0101);
    rdChk(OFF_INT_PAY, 32'h0000_BEEF);
    rdChk(OFF_INT_HDR, 32'hC7FF_0101);
    wr(OFF_INT_PAY, 32'h0);
    rdChk(OFF_INT_HDR, 32'h0);
    for (i = 0; i < 4; i++) begin
      farEnd.intxMsg(16'h0200 + 16'(i), 2'(i), 1'h1);
      rdChk(OFF_INT_HDR, {3'h5, 2'(i), 11'h0, 16'h0200 + 16'(i)});
      rdChk(OFF_INT_PAY, 32'h0);
      wr(i[0] ? OFF_INT_PAY : OFF_INT_HDR, 32'hFFFF_FFFF);
    end
    rdChk(OFF_INTX_STAT, 32'h000F_0000);
    farEnd.intxMsg(16'h0201, 2'h1, 1'h0);
    rdChk(OFF_INT_HDR, 32'h8800_0201);
    rdChk(OFF_INTX_STAT, 32'h000D_0000);
    for (i = 0; i < 4; i++) msi(64'h0000_0000_1234_5000, 1'h0);
    rdChk(OFF_QSTAT, 32'h000D_0000);
    wr(OFF_QSTAT, 32'h0008_0000);
    rdChk(OFF_QSTAT, 32'h0005_0000);
    @(posedge clock);
    rootPortMode <= 1'h0;
    rdChk(OFF_MSI_BASE, 32'h0);
    rdChk(OFF_ERR_HEAD, 32'h0);
    rdChk(OFF_INT_HDR, 32'h0);
    rdChk(OFF_INT_PAY, 32'h0);
    rdChk(OFF_INTX_STAT, 32'h0);
    wr(OFF_ERR_HEAD, 32'h0);
    @(posedge clock);
    rootPortMode <= 1'h1;
    rdChk(OFF_ERR_HEAD, errWord(16'h1234, 2'h2));
    axiRd(12'h100, d, rs);
    chk2(rs, RESP_SLVERR);
    chk32(d, 32'h0);
    close_out();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    fail("run timeout");
    close_out();
  end
endmodule // rpmq_root_port_msg_test
